// ### rtl/serial_regs_pkg.sv
// constants for the serial channel command, pointer and interrupt-enable registers
package serial_regs_pkg;

    // pointer values of the internal registers
    localparam logic [3:0] PTR_COMMAND      = 4'h0;
    localparam logic [3:0] PTR_LOW_IRQ_EN   = 4'h1;
    localparam logic [3:0] PTR_VECTOR       = 4'h2;
    localparam logic [3:0] PTR_FRAME_LOW    = 4'h6;
    localparam logic [3:0] PTR_FRAME_HIGH   = 4'h7;
    localparam logic [3:0] PTR_BAUD_LOW     = 4'hd;
    localparam logic [3:0] PTR_HIGH_IRQ_EN  = 4'hf;

    // command register field positions
    localparam int CMD_FIRST_MSB  = 7;
    localparam int CMD_FIRST_LSB  = 6;
    localparam int CMD_SECOND_MSB = 5;

    // first reset command codes
    localparam logic [1:0] FIRST_NONE         = 2'h0;
    localparam logic [1:0] FIRST_RX_CRC       = 2'h1;
    localparam logic [1:0] FIRST_TX_CRC       = 2'h2;
    localparam logic [1:0] FIRST_CLR_UNDERRUN = 2'h3;

    // second reset command codes (hex values of the six-bit field)
    localparam logic [5:0] SECOND_CLR_EXT     = 6'h10;
    localparam logic [5:0] SECOND_SEND_ABORT  = 6'h18;
    localparam logic [5:0] SECOND_ARM_NEXT_RX = 6'h20;
    localparam logic [5:0] SECOND_CLR_TX_PEND = 6'h28;
    localparam logic [5:0] SECOND_CLR_EXCEPT  = 6'h30;
    localparam logic [5:0] SECOND_CLR_HIGHEST = 6'h38;

    // low interrupt-enable fields
    localparam int LOW_RX_MODE_MSB = 4;
    localparam int LOW_RX_MODE_LSB = 3;
    localparam int LOW_PARITY_BIT  = 2;
    localparam int LOW_TX_BIT      = 1;
    localparam int LOW_EXT_BIT     = 0;

    // high interrupt-enable fields
    localparam int HIGH_BREAK_BIT    = 7;
    localparam int HIGH_UNDERRUN_BIT = 6;
    localparam int HIGH_CTS_BIT      = 5;
    localparam int HIGH_SYNC_BIT     = 4;
    localparam int HIGH_DCD_BIT      = 3;
    localparam int HIGH_FRAME_Q_BIT  = 2;
    localparam int HIGH_ZERO_BIT     = 1;
    localparam int HIGH_SECOND_BIT   = 0;

    // receive interrupt modes
    localparam logic [1:0] RX_MODE_OFF       = 2'h0;
    localparam logic [1:0] RX_MODE_FIRST     = 2'h1;
    localparam logic [1:0] RX_MODE_EVERY     = 2'h2;
    localparam logic [1:0] RX_MODE_EXCEPTION = 2'h3;

    // pending source codes
    localparam logic [2:0] VEC_TX_EMPTY  = 3'h4;
    localparam logic [2:0] VEC_EXT       = 3'h5;
    localparam logic [2:0] VEC_RX_AVAIL  = 3'h6;
    localparam logic [2:0] VEC_EXCEPTION = 3'h7;

    // reset values
    localparam logic [7:0] RESET_LOW_IRQ_EN  = 8'h00;
    localparam logic [7:0] RESET_HIGH_IRQ_EN = 8'h00;
    localparam logic [7:0] RESET_BAUD_LOW    = 8'h00;
    localparam logic [3:0] RESET_POINTER     = 4'h0;
    localparam logic [7:0] LOW_RESERVED_ONES = 8'he0;

endpackage

// ### rtl/source_vector.sv
// priority encoder that turns the gated pending sources into a vector code
`timescale 1ns/1ps
module source_vector
    import serial_regs_pkg::*;
(
    input  wire logic       exception_pend,
    input  wire logic       rx_pend,
    input  wire logic       ext_pend,
    input  wire logic       tx_pend,
    output logic            any_pend,
    output logic [2:0]      code
);

    // exception first, then receive, external, transmit
    always_comb
    begin
        any_pend = exception_pend | rx_pend | ext_pend | tx_pend;
        if (exception_pend)
        begin
            code = VEC_EXCEPTION;
        end
        else if (rx_pend)
        begin
            code = VEC_RX_AVAIL;
        end
        else if (ext_pend)
        begin
            code = VEC_EXT;
        end
        else if (tx_pend)
        begin
            code = VEC_TX_EMPTY;
        end
        else
        begin
            // nothing pending: lowest code, as the idle vector
            code = 3'h0;
        end
    end

endmodule

// ### rtl/serial_command_and_irq_enable_regs.sv
// command, pointer and interrupt-enable register set of one serial channel
// Function
// - command splits 7:6 first, 5:0 second/pointer
// - first command 3 underrun, 2 tx crc, 1 rx crc
// - after clear underrun, append crc when underrun ends
// - decode second commands 38,30,28,20,18,10
// - pointer values 0 to F select registers
// - low enable 4:3 selects receive interrupt mode
// - low enable bit 2 gates parity interrupt
// - low enable bit 1 enables transmit interrupt
// - low enable bit 0 enables external status
// - high enable bit 7 break/abort interrupt
// - high enable bit 6 underrun/end-of-message interrupt
// - high bits 5,4,3 cts, sync, carrier
// - high bit 2 enables frame status queue
// - high bit 1 baud zero interrupt
// - high bit 0 enables secondary control
// - pointer F is high enable and pointer
// - vector at 2 channel 1 only, 2:0
// - vector 7 exception,6 rx,5 ext,4 tx
// - baud compare low byte at pointer D
// - pointer access paired, reverts to zero
// - frame queue on: regs 7/6 remapped
`timescale 1ns/1ps
module serial_command_and_irq_enable_regs
    import serial_regs_pkg::*;
#(
    parameter bit CHANNEL_ONE = 1'b1            // vector register only on channel 1
)
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    // cpu access to this channel
    input  wire logic       cpu_wr,
    input  wire logic       cpu_rd,
    input  wire logic [7:0] cpu_wdata,
    output logic [7:0]      cpu_rdata,
    // raw events from the serial engine
    input  wire logic       rx_char,
    input  wire logic       rx_exception,
    input  wire logic       parity_err,
    input  wire logic       tx_empty,
    input  wire logic       break_abort,
    input  wire logic       tx_underrun,
    input  wire logic       cts_change,
    input  wire logic       sync_event,
    input  wire logic       dcd_change,
    input  wire logic       baud_zero,
    input  wire logic [7:0] frame_status_low,
    input  wire logic [7:0] frame_status_high,
    input  wire logic [7:0] other_rd_data,      // engine registers not held here
    // command pulses and controls to the engine
    output logic            rx_crc_reset,
    output logic            tx_crc_reset,
    output logic            send_abort,
    output logic            tx_crc_append,
    output logic            frame_status_queue_enable,
    output logic            secondary_control_enable,
    output logic            write7_secondary,
    output logic [7:0]      baud_compare_low_byte,
    output logic [3:0]      selected_pointer,
    output logic            irq
);

    logic [3:0] ptr_q, ptr_d;                   // pointer for the next access
    logic [7:0] low_en_q, low_en_d;             // low interrupt enable
    logic [7:0] high_en_q, high_en_d;           // high interrupt enable
    logic [7:0] baud_q, baud_d;                 // baud compare low byte
    logic       rx_first_q, rx_first_d;         // armed for next/first character
    logic       ext_pend_q, ext_pend_d;         // latched external status
    logic       exc_pend_q, exc_pend_d;         // latched exception
    logic       tx_pend_q, tx_pend_d;           // latched transmitter interrupt
    logic       rx_pend_q, rx_pend_d;           // latched receive interrupt
    logic       und_armed_q, und_armed_d;       // clear-underrun given
    logic       crc_app_q, crc_app_d;           // append pulse to engine
    logic       rxc_q, rxc_d, txc_q, txc_d, ab_q, ab_d;
    logic [7:0] rdata_q, rdata_d;
    logic       irq_q, irq_d;
    logic [2:0] vec_code;
    logic       cmd_write;
    logic [1:0] first_cmd;
    logic [5:0] second_field;
    logic       ext_evt, exc_evt, rx_evt;
    logic       prev_und_q, prev_und_d;         // for underrun end detection

    assign cmd_write    = cpu_wr && (ptr_q == PTR_COMMAND);
    assign first_cmd    = cpu_wdata[CMD_FIRST_MSB:CMD_FIRST_LSB];
    assign second_field = cpu_wdata[CMD_SECOND_MSB:0];

    // gated events; enables below come straight from the stored fields
    always_comb
    begin
        ext_evt = low_en_q[LOW_EXT_BIT] &&
                  ((break_abort && high_en_q[HIGH_BREAK_BIT]) ||
                   (tx_underrun && high_en_q[HIGH_UNDERRUN_BIT]) ||
                   (cts_change && high_en_q[HIGH_CTS_BIT]) ||
                   (sync_event && high_en_q[HIGH_SYNC_BIT]) ||
                   (dcd_change && high_en_q[HIGH_DCD_BIT]) ||
                   (baud_zero && high_en_q[HIGH_ZERO_BIT]));
        // parity only counts as exception when its enable is set
        exc_evt = (low_en_q[LOW_RX_MODE_MSB:LOW_RX_MODE_LSB] != RX_MODE_OFF) &&
                  (rx_exception || (parity_err && low_en_q[LOW_PARITY_BIT]));
        // receive character interrupt by mode
        unique case (low_en_q[LOW_RX_MODE_MSB:LOW_RX_MODE_LSB])
            RX_MODE_OFF:       rx_evt = 1'b0;
            RX_MODE_FIRST:     rx_evt = rx_char && rx_first_q;
            RX_MODE_EVERY:     rx_evt = rx_char;
            RX_MODE_EXCEPTION: rx_evt = 1'b0;
        endcase
    end

    source_vector u_vec
    (
        .exception_pend (exc_pend_q),
        .rx_pend        (rx_pend_q),
        .ext_pend       (ext_pend_q),
        .tx_pend        (tx_pend_q),
        .any_pend       (),
        .code           (vec_code)
    );

    // next-state logic for pointer, registers, pending flags, commands
    always_comb
    begin
        ptr_d       = ptr_q;
        low_en_d    = low_en_q;
        high_en_d   = high_en_q;
        baud_d      = baud_q;
        rx_first_d  = rx_first_q;
        rxc_d       = 1'b0;
        txc_d       = 1'b0;
        ab_d        = 1'b0;
        crc_app_d   = 1'b0;
        und_armed_d = und_armed_q;
        prev_und_d  = tx_underrun;
        rdata_d     = rdata_q;
        // set wins over clear: clears first, events ored in afterwards
        ext_pend_d  = ext_pend_q;
        exc_pend_d  = exc_pend_q;
        tx_pend_d   = tx_pend_q;
        rx_pend_d   = rx_pend_q;
        if (cpu_wr)
        begin
            if (ptr_q == PTR_COMMAND)
            begin
                unique case (first_cmd)
                    FIRST_NONE:         ;
                    FIRST_RX_CRC:       rxc_d = 1'b1;
                    FIRST_TX_CRC:       txc_d = 1'b1;
                    FIRST_CLR_UNDERRUN: und_armed_d = 1'b1;
                endcase
                // low three bits zero and nonzero 5:4 mark a command; 0x08 stays a pointer
                if (second_field[2:0] == 3'h0 && second_field[5:4] != 2'h0)
                begin
                    unique case (second_field)
                        SECOND_CLR_HIGHEST:
                        begin
                            if (exc_pend_q)
                                exc_pend_d = 1'b0;
                            else if (rx_pend_q)
                                rx_pend_d = 1'b0;
                            else if (ext_pend_q)
                                ext_pend_d = 1'b0;
                            else
                                tx_pend_d = 1'b0;
                        end
                        SECOND_CLR_EXCEPT:  exc_pend_d = 1'b0;
                        SECOND_CLR_TX_PEND: tx_pend_d = 1'b0;
                        SECOND_ARM_NEXT_RX: rx_first_d = 1'b1;
                        SECOND_SEND_ABORT:  ab_d = 1'b1;
                        SECOND_CLR_EXT:     ext_pend_d = 1'b0;
                        default:            ;
                    endcase
                end
                else if (second_field[5:4] == 2'h0)
                begin
                    ptr_d = second_field[3:0];
                end
            end
            else
            begin
                unique case (ptr_q)
                    PTR_LOW_IRQ_EN:  low_en_d = cpu_wdata;
                    PTR_BAUD_LOW:    baud_d = cpu_wdata;
                    PTR_HIGH_IRQ_EN: high_en_d = cpu_wdata;
                    default:         ;
                endcase
                ptr_d = RESET_POINTER;
            end
        end
        else if (cpu_rd)
        begin
            unique case (ptr_q)
                PTR_LOW_IRQ_EN:  rdata_d = low_en_q | LOW_RESERVED_ONES;
                PTR_VECTOR:      rdata_d = CHANNEL_ONE ? {5'h00, vec_code}
                                                       : other_rd_data;
                PTR_BAUD_LOW:    rdata_d = baud_q;
                PTR_HIGH_IRQ_EN: rdata_d = high_en_q;
                PTR_FRAME_LOW:   rdata_d = high_en_q[HIGH_FRAME_Q_BIT] ?
                                           frame_status_low : other_rd_data;
                PTR_FRAME_HIGH:  rdata_d = high_en_q[HIGH_FRAME_Q_BIT] ?
                                           frame_status_high : other_rd_data;
                default:         rdata_d = other_rd_data;
            endcase
            ptr_d = RESET_POINTER;
        end
        // append crc when an underrun ends after the clear command
        if (und_armed_q && prev_und_q && !tx_underrun)
        begin
            crc_app_d   = 1'b1;
            und_armed_d = 1'b0;
        end
        if (rx_evt && rx_first_q)
            rx_first_d = 1'b0;
        ext_pend_d = ext_pend_d | ext_evt;
        exc_pend_d = exc_pend_d | exc_evt;
        rx_pend_d  = rx_pend_d | rx_evt;
        tx_pend_d  = tx_pend_d | (tx_empty && low_en_q[LOW_TX_BIT]);
        irq_d      = ext_pend_d | exc_pend_d | rx_pend_d | tx_pend_d;
    end

    // registers only
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            ptr_q       <= RESET_POINTER;
            low_en_q    <= RESET_LOW_IRQ_EN;
            high_en_q   <= RESET_HIGH_IRQ_EN;
            baud_q      <= RESET_BAUD_LOW;
            rx_first_q  <= 1'b1;
            ext_pend_q  <= 1'b0;
            exc_pend_q  <= 1'b0;
            tx_pend_q   <= 1'b0;
            rx_pend_q   <= 1'b0;
            und_armed_q <= 1'b0;
            crc_app_q   <= 1'b0;
            rxc_q       <= 1'b0;
            txc_q       <= 1'b0;
            ab_q        <= 1'b0;
            rdata_q     <= 8'h00;
            irq_q       <= 1'b0;
            prev_und_q  <= 1'b0;
        end
        else
        begin
            ptr_q       <= ptr_d;
            low_en_q    <= low_en_d;
            high_en_q   <= high_en_d;
            baud_q      <= baud_d;
            rx_first_q  <= rx_first_d;
            ext_pend_q  <= ext_pend_d;
            exc_pend_q  <= exc_pend_d;
            tx_pend_q   <= tx_pend_d;
            rx_pend_q   <= rx_pend_d;
            und_armed_q <= und_armed_d;
            crc_app_q   <= crc_app_d;
            rxc_q       <= rxc_d;
            txc_q       <= txc_d;
            ab_q        <= ab_d;
            rdata_q     <= rdata_d;
            irq_q       <= irq_d;
            prev_und_q  <= prev_und_d;
        end
    end

    assign cpu_rdata                 = rdata_q;
    assign rx_crc_reset              = rxc_q;
    assign tx_crc_reset              = txc_q;
    assign send_abort                = ab_q;
    assign tx_crc_append             = crc_app_q;
    assign frame_status_queue_enable = high_en_q[HIGH_FRAME_Q_BIT];
    assign write7_secondary          = high_en_q[HIGH_FRAME_Q_BIT];
    assign secondary_control_enable  = high_en_q[HIGH_SECOND_BIT];
    assign baud_compare_low_byte     = baud_q;
    assign selected_pointer          = ptr_q;
    assign irq                       = irq_q;

    // assertions
    sequence s_ptr_load;
        cpu_wr && ptr_q == PTR_COMMAND && cpu_wdata[7:4] == 4'h0 && cpu_wdata[3:0] != 4'h0;
    endsequence
    sequence s_access;
        (cpu_wr || cpu_rd) && ptr_q != PTR_COMMAND;
    endsequence

    property p_ptr_load;
        @(posedge clk) disable iff (!reset_n)
        s_ptr_load |=> ptr_q == $past(cpu_wdata[3:0]);
    endproperty
    a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");

    property p_revert;
        @(posedge clk) disable iff (!reset_n)
        s_access |=> ptr_q == RESET_POINTER;
    endproperty
    a_revert: assert property (p_revert) else $error("pointer did not revert");

    property p_rx_crc;
        @(posedge clk) disable iff (!reset_n)
        cmd_write && first_cmd == FIRST_RX_CRC |=> rx_crc_reset && !tx_crc_reset;
    endproperty
    a_rx_crc: assert property (p_rx_crc) else $error("rx crc reset missing");

    property p_tx_crc;
        @(posedge clk) disable iff (!reset_n)
        cmd_write && first_cmd == FIRST_TX_CRC |=> tx_crc_reset && !rx_crc_reset;
    endproperty
    a_tx_crc: assert property (p_tx_crc) else $error("tx crc reset missing");

    property p_abort;
        @(posedge clk) disable iff (!reset_n)
        cmd_write && second_field == SECOND_SEND_ABORT |=> send_abort ##1 !send_abort;
    endproperty
    a_abort: assert property (p_abort) else $error("abort pulse wrong");

    property p_high_en;
        @(posedge clk) disable iff (!reset_n)
        cpu_wr && ptr_q == PTR_HIGH_IRQ_EN |=>
            frame_status_queue_enable == $past(cpu_wdata[HIGH_FRAME_Q_BIT]) &&
            secondary_control_enable == $past(cpu_wdata[HIGH_SECOND_BIT]);
    endproperty
    a_high_en: assert property (p_high_en) else $error("high enable not stored");

    property p_vector;
        @(posedge clk) disable iff (!reset_n)
        cpu_rd && ptr_q == PTR_VECTOR && CHANNEL_ONE |=> cpu_rdata[7:3] == 5'h00;
    endproperty
    a_vector: assert property (p_vector) else $error("vector high bits set");

    property p_ext_gate;
        @(posedge clk) disable iff (!reset_n)
        !low_en_q[LOW_EXT_BIT] && !ext_pend_q |=> !ext_pend_q;
    endproperty
    a_ext_gate: assert property (p_ext_gate) else $error("ext status not gated");

    property p_baud;
        @(posedge clk) disable iff (!reset_n)
        cpu_wr && ptr_q == PTR_BAUD_LOW |=> baud_compare_low_byte == $past(cpu_wdata);
    endproperty
    a_baud: assert property (p_baud) else $error("baud low not stored");

endmodule

// ### tb/serial_engine_model.sv
// far-side serial engine model: event pulses and read-back data
`timescale 1ns/1ps
module serial_engine_model
#(
    parameter logic [7:0] FS_LOW  = 8'h5a,  // frame status lower entry
    parameter logic [7:0] FS_HIGH = 8'ha5,  // frame status upper entry
    parameter logic [7:0] OTHER   = 8'h3c   // engine register read data
)
(
    input  wire logic       clk,
    input  wire logic [9:0] fire,
    output logic [9:0]      ev,
    output logic [7:0]      fs_low,
    output logic [7:0]      fs_high,
    output logic [7:0]      other
);
    // events launch on a clock edge, as the real engine's would
    always_ff @(posedge clk)
    begin
        ev <= fire;
    end
    assign fs_low  = FS_LOW;
    assign fs_high = FS_HIGH;
    assign other   = OTHER;
endmodule

// ### tb/test_serial_command_and_irq_enable_regs.sv
// self-checking bench for the command and interrupt-enable registers
`timescale 1ns/1ps
module test_serial_command_and_irq_enable_regs;
    import serial_regs_pkg::*;
    logic       clk;
    logic       reset_n;
    logic       cpu_wr;
    logic       cpu_rd;
    logic [7:0] cpu_wdata;
    logic [7:0] cpu_rdata;
    logic [9:0] fire;       // event requests to the engine model
    logic [9:0] ev;         // events as the engine drives them
    logic [7:0] fs_low;
    logic [7:0] fs_high;
    logic [7:0] other;
    logic       rx_crc_reset, tx_crc_reset, send_abort, tx_crc_append;
    logic       fq_en, sec_en, w7_sec, irq;
    logic [7:0] baud;
    logic [3:0] ptr;
    int         mismatches = 0;
    int         n_checks   = 0;
    int         cyc        = 0;
    int         low_m, high_m, baud_m;                  // behavioural register copies
    logic [5:0] codes[$] = '{6'h10, 6'h18, 6'h20, 6'h28, 6'h30, 6'h38};
    logic [7:0] d;
    logic       seen;

    serial_engine_model u_eng (.clk(clk), .fire(fire), .ev(ev), .fs_low(fs_low),
        .fs_high(fs_high), .other(other));

    serial_command_and_irq_enable_regs u_dut (.clk(clk), .reset_n(reset_n),
        .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
        .rx_char(ev[0]), .rx_exception(ev[1]), .parity_err(ev[2]), .tx_empty(ev[3]),
        .break_abort(ev[4]), .tx_underrun(ev[5]), .cts_change(ev[6]),
        .sync_event(ev[7]), .dcd_change(ev[8]), .baud_zero(ev[9]),
        .frame_status_low(fs_low), .frame_status_high(fs_high), .other_rd_data(other),
        .rx_crc_reset(rx_crc_reset), .tx_crc_reset(tx_crc_reset),
        .send_abort(send_abort), .tx_crc_append(tx_crc_append),
        .frame_status_queue_enable(fq_en), .secondary_control_enable(sec_en),
        .write7_secondary(w7_sec), .baud_compare_low_byte(baud),
        .selected_pointer(ptr), .irq(irq));

    // free-running 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // hang guard: the whole run needs far fewer cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            mismatches++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask

    // one strobe cycle after an idle edge, so back-to-back calls never
    // lower and raise the strobe in one time step; returns just after the taking edge
    task automatic wr(input logic [7:0] v);
        @(posedge clk);
        #1 cpu_wr = 1'b1;
        cpu_wdata = v;
        @(posedge clk);
        #1 cpu_wr = 1'b0;
    endtask

    task automatic rd(output logic [7:0] v);
        @(posedge clk);
        #1 cpu_rd = 1'b1;
        @(posedge clk);
        #1 cpu_rd = 1'b0;
        v = cpu_rdata;
    endtask

    // pointer write and access always travel as a pair
    task automatic reg_wr(input logic [3:0] p, input logic [7:0] v);
        wr({4'h0, p});
        wr(v);
    endtask

    task automatic reg_rd(input logic [3:0] p, output logic [7:0] v);
        wr({4'h0, p});
        rd(v);
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic pulse(input int b);
        fire[b] = 1'b1;
        step(1);
        fire[b] = 1'b0;
    endtask

    initial
    begin
        reset_n = 1'b0; cpu_wr = 1'b0; cpu_rd = 1'b0; cpu_wdata = 8'h00; fire = 10'h000;
        low_m = 0; high_m = 0; baud_m = 0;
        void'($urandom(88));
        repeat (5) @(posedge clk);
        #1 reset_n = 1'b1;
        // reset values, reserved ones in the low enable
        reg_rd(PTR_LOW_IRQ_EN, d); chk8(d, LOW_RESERVED_ONES | 8'(low_m));
        reg_rd(PTR_HIGH_IRQ_EN, d); chk8(d, 8'(high_m));
        reg_rd(PTR_BAUD_LOW, d); chk8(d, 8'(baud_m));
        $display("test reset done");
        // random register contents, pointer falls back after each access
        repeat (4)
        begin
            low_m = $urandom & 8'h1f; high_m = $urandom & 8'hff; baud_m = $urandom & 8'hff;
            reg_wr(PTR_LOW_IRQ_EN, 8'(low_m)); chk8({4'h0, ptr}, 8'h00);
            reg_wr(PTR_HIGH_IRQ_EN, 8'(high_m)); chk8({4'h0, ptr}, 8'h00);
            reg_wr(PTR_BAUD_LOW, 8'(baud_m)); chk8(baud, 8'(baud_m));
            chk1(fq_en, high_m[2]);
            chk1(w7_sec, high_m[2]);
            chk1(sec_en, high_m[0]);
            reg_rd(PTR_LOW_IRQ_EN, d); chk8(d, LOW_RESERVED_ONES | 8'(low_m));
            reg_rd(PTR_HIGH_IRQ_EN, d); chk8(d, 8'(high_m));
            reg_rd(PTR_BAUD_LOW, d); chk8(d, 8'(baud_m));
        end
        $display("test registers done");
        // every first command code; rx and tx crc resets each a one-cycle pulse
        for (int c = 0; c < 4; c++)
        begin
            wr({2'(c), 6'h00});
            chk1(rx_crc_reset, c == 1);
            chk1(tx_crc_reset, c == 2);
            step(1);
            chk1(rx_crc_reset | tx_crc_reset, 1'b0);
        end
        // underrun ends after the clear command: append follows
        seen = 1'b0;
        pulse(5);
        repeat (6)
        begin
            step(1);
            seen = seen | tx_crc_append;
        end
        chk1(seen, 1'b1);
        // every second command code; none is taken as a pointer
        foreach (codes[i])
        begin
            wr({2'b00, codes[i]});
            chk1(send_abort, codes[i] == SECOND_SEND_ABORT);
            chk8({4'h0, ptr}, 8'h00);
        end
        $display("test commands done");
        // transmit source masked, then enabled
        reg_wr(PTR_HIGH_IRQ_EN, 8'h00);
        reg_wr(PTR_LOW_IRQ_EN, 8'h00);
        pulse(3); step(3); chk1(irq, 1'b0);
        wr({2'b00, SECOND_CLR_TX_PEND});
        reg_wr(PTR_LOW_IRQ_EN, 8'h02);
        pulse(3); step(3); chk1(irq, 1'b1);
        reg_rd(PTR_VECTOR, d); chk8(d, {5'h00, VEC_TX_EMPTY});
        wr({2'b00, SECOND_CLR_TX_PEND}); step(3); chk1(irq, 1'b0);
        // clear-to-send change through the external status path
        reg_wr(PTR_LOW_IRQ_EN, 8'h01);
        reg_wr(PTR_HIGH_IRQ_EN, 8'h20);
        pulse(6); step(3); chk1(irq, 1'b1);
        reg_rd(PTR_VECTOR, d); chk8(d, {5'h00, VEC_EXT});
        wr({2'b00, SECOND_CLR_EXT}); step(3); chk1(irq, 1'b0);
        // parity exception outranks a first character; clear-highest takes them in order
        reg_wr(PTR_LOW_IRQ_EN, 8'h0c);
        pulse(2); step(1); pulse(0); step(3); chk1(irq, 1'b1);
        reg_rd(PTR_VECTOR, d); chk8(d, {5'h00, VEC_EXCEPTION});
        wr({2'b00, SECOND_CLR_HIGHEST}); step(1);
        reg_rd(PTR_VECTOR, d); chk8(d, {5'h00, VEC_RX_AVAIL});
        wr({2'b00, SECOND_CLR_HIGHEST}); step(1); chk1(irq, 1'b0);
        pulse(0); step(3); chk1(irq, 1'b0);
        $display("test interrupts done");
        // frame queue off: engine data; on: queue entries
        reg_wr(PTR_HIGH_IRQ_EN, 8'h00);
        reg_rd(PTR_FRAME_HIGH, d); chk8(d, other);
        reg_rd(4'h3, d); chk8(d, other);
        reg_rd(4'h8, d); chk8(d, other);
        reg_wr(PTR_HIGH_IRQ_EN, 8'h04);
        reg_rd(PTR_FRAME_HIGH, d); chk8(d, fs_high);
        reg_rd(PTR_FRAME_LOW, d); chk8(d, fs_low);
        $display("test frame queue done");
        summarize();
    end
endmodule
